// ### logic/ppc_map.svh
// Constants of the priority pin crossbar
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// ==========================================================
// Sizes
`define PPC_NPIN        32
`define PPC_NPIN_ALL    39
`define PPC_NFUNC       21
`define PPC_PIDX_W      6
`define PPC_FIDX_W      5
`define PPC_NONE        5'h1f
// Fixed async pins per variant
`define PPC_TX_BIG      6'h01
`define PPC_RX_BIG      6'h02
`define PPC_TX_SMALL    6'h04
`define PPC_RX_SMALL    6'h05
// Function indices in priority order
`define PPC_F_TX        5'h00
`define PPC_F_RX        5'h01
`define PPC_F_SCK       5'h02
`define PPC_F_MISO      5'h03
`define PPC_F_MOSI      5'h04
`define PPC_F_NSS       5'h05
`define PPC_F_SDA       5'h06
`define PPC_F_SCL       5'h07
`define PPC_F_CP0       5'h08
`define PPC_F_CP0A      5'h09
`define PPC_F_CP1       5'h0a
`define PPC_F_CP1A      5'h0b
`define PPC_F_SYSCK     5'h0c
`define PPC_F_CEX0      5'h0d
`define PPC_F_ECI       5'h13
`define PPC_F_T0        5'h14
// Select register A bits
`define PPC_A_UART      0
`define PPC_A_SPI       1
`define PPC_A_SMB       2
`define PPC_A_SYSCK     3
`define PPC_A_CP0       4
`define PPC_A_CP0A      5
`define PPC_A_CP1       6
`define PPC_A_CP1A      7
// Select register B bits, capture count limit, slave select mode bit
`define PPC_B_ECI       3
`define PPC_B_T0        4
`define PPC_B_T1        5
`define PPC_CEX_MAX     3'h6
`define PPC_NSS_4WIRE   1
// Reset values
`define PPC_RST_KIND    39'h7f_ffff_ffff
`define PPC_RST_ZERO    39'h00_0000_0000
`endif

// ### logic/ppc_pkg.sv
// Types of the priority pin crossbar
`default_nettype none
package ppc_pkg;
    `include "ppc_map.svh"
    typedef logic [`PPC_NPIN_ALL-1:0] ppc_pins_t;
    typedef logic [7:0]               ppc_byte_t;
    typedef struct packed {
        ppc_pins_t pin_out;
        ppc_pins_t pin_oe;
        ppc_pins_t pin_pullup;
        ppc_pins_t port_read;
        ppc_pins_t pin_periph_in;
    } ppc_state_s;
endpackage
`default_nettype wire

// ### logic/ppc_decoder.sv
// Combinational priority decoder: function to pin placement
`default_nettype none
`include "ppc_map.svh"
module ppc_decoder (
    // Requests and masks
    input  wire logic [`PPC_NFUNC-1:0]   func_req,
    input  wire logic [`PPC_NPIN-1:0]    bypass,
    input  wire logic                    big_variant,
    // Placement
    output logic [`PPC_NFUNC*`PPC_PIDX_W-1:0] func_pin,
    output logic [`PPC_NFUNC-1:0]        func_placed,
    output logic [`PPC_NPIN*`PPC_FIDX_W-1:0]  pin_func
);
    import ppc_pkg::*;
    logic [`PPC_NPIN-1:0] taken;
    logic [`PPC_PIDX_W-1:0] tx_pin;
    logic [`PPC_PIDX_W-1:0] rx_pin;
    logic found;

    // Walk functions in fixed priority order
    always_comb begin
        tx_pin = big_variant ? `PPC_TX_BIG : `PPC_TX_SMALL;
        rx_pin = big_variant ? `PPC_RX_BIG : `PPC_RX_SMALL;
        taken = bypass;
        func_pin = '0;
        func_placed = '0;
        pin_func = {`PPC_NPIN{`PPC_NONE}};
        found = 1'b0;
        // Async pair on fixed pins, both together
        if (func_req[`PPC_F_TX]) begin
            taken[tx_pin[4:0]] = 1'b1;
            taken[rx_pin[4:0]] = 1'b1;
            func_pin[0 +: `PPC_PIDX_W] = tx_pin;
            func_pin[`PPC_PIDX_W +: `PPC_PIDX_W] = rx_pin;
            func_placed[1:0] = 2'b11;
            pin_func[tx_pin[4:0]*`PPC_FIDX_W +: `PPC_FIDX_W] = `PPC_F_TX;
            pin_func[rx_pin[4:0]*`PPC_FIDX_W +: `PPC_FIDX_W] = `PPC_F_RX;
        end
        for (int f = 2; f < `PPC_NFUNC; f++) begin
            found = 1'b0;
            if (func_req[f]) begin
                for (int p = 0; p < `PPC_NPIN; p++) begin
                    if (!found && !taken[p]) begin
                        found = 1'b1;
                        taken[p] = 1'b1;
                        func_pin[f*`PPC_PIDX_W +: `PPC_PIDX_W] =
                            `PPC_PIDX_W'(p);
                        pin_func[p*`PPC_FIDX_W +: `PPC_FIDX_W] =
                            `PPC_FIDX_W'(f);
                    end
                end
                func_placed[f] = found;
            end
        end
    end
endmodule // ppc_decoder
`default_nettype wire

// ### logic/ppc_crossbar.sv
// Priority pin crossbar top: placement, pad control, read-back
`default_nettype none
`include "ppc_map.svh"
module ppc_crossbar (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Software configuration
    input  wire logic [7:0]           peripheral_select_reg_a,
    input  wire logic [7:0]           peripheral_select_reg_b,
    input  wire logic [1:0]           slave_select_mode_field,
    input  wire logic                 big_variant,
    input  wire logic                 matrix_enable_bit,
    input  wire logic                 pullup_disable_bit,
    input  wire ppc_pkg::ppc_pins_t   pin_bypass_mask,
    input  wire ppc_pkg::ppc_pins_t   pin_input_kind_mask,
    input  wire ppc_pkg::ppc_pins_t   pin_drive_kind_mask,
    input  wire ppc_pkg::ppc_pins_t   port_latch,
    // Peripheral outputs toward pins
    input  wire logic [`PPC_NFUNC-1:0] periph_out,
    input  wire logic [`PPC_NFUNC-1:0] periph_oe,
    // Pads
    input  wire ppc_pkg::ppc_pins_t   pin_in,
    output logic [`PPC_NPIN_ALL-1:0]  pin_out,
    output logic [`PPC_NPIN_ALL-1:0]  pin_oe,
    output logic [`PPC_NPIN_ALL-1:0]  pin_pullup,
    // Read-back and peripheral inputs
    output logic [`PPC_NPIN_ALL-1:0]  port_read,
    output logic [`PPC_NFUNC-1:0]     periph_in,
    output logic [`PPC_NFUNC-1:0]     periph_placed
);
    import ppc_pkg::*;

    // ==========================================================
    // State
    ppc_state_s state;
    ppc_state_s next_state;
    ppc_pins_t  pin_meta;
    ppc_pins_t  pin_sync;
    logic [`PPC_NFUNC-1:0] func_req;
    logic [`PPC_NFUNC*`PPC_PIDX_W-1:0] func_pin;
    logic [`PPC_NFUNC-1:0] func_placed;
    logic [`PPC_NPIN*`PPC_FIDX_W-1:0] pin_func;
    logic [`PPC_NFUNC-1:0] next_periph_in;
    logic [`PPC_NFUNC-1:0] periph_in_q;
    logic [`PPC_NFUNC-1:0] placed_q;

    // ==========================================================
    // Function requests from the select registers
    always_comb begin
        func_req = '0;
        if (matrix_enable_bit) begin
            func_req[`PPC_F_TX] = peripheral_select_reg_a[`PPC_A_UART];
            func_req[`PPC_F_RX] = peripheral_select_reg_a[`PPC_A_UART];
            func_req[`PPC_F_SCK] = peripheral_select_reg_a[`PPC_A_SPI];
            func_req[`PPC_F_MISO] = peripheral_select_reg_a[`PPC_A_SPI];
            func_req[`PPC_F_MOSI] = peripheral_select_reg_a[`PPC_A_SPI];
            func_req[`PPC_F_NSS] = peripheral_select_reg_a[`PPC_A_SPI]
                && slave_select_mode_field[`PPC_NSS_4WIRE];
            func_req[`PPC_F_SDA] = peripheral_select_reg_a[`PPC_A_SMB];
            func_req[`PPC_F_SCL] = peripheral_select_reg_a[`PPC_A_SMB];
            func_req[`PPC_F_CP0] = peripheral_select_reg_a[`PPC_A_CP0];
            func_req[`PPC_F_CP0A] = peripheral_select_reg_a[`PPC_A_CP0A];
            func_req[`PPC_F_CP1] = peripheral_select_reg_a[`PPC_A_CP1];
            func_req[`PPC_F_CP1A] = peripheral_select_reg_a[`PPC_A_CP1A];
            func_req[`PPC_F_SYSCK] = peripheral_select_reg_a[`PPC_A_SYSCK];
            for (int k = 0; k < 6; k++) begin
                func_req[`PPC_F_CEX0 + k] = (3'(k) <
                    peripheral_select_reg_b[2:0])
                    && (peripheral_select_reg_b[2:0] <= `PPC_CEX_MAX);
            end
            func_req[`PPC_F_ECI] = peripheral_select_reg_b[`PPC_B_ECI];
            // Timer1 has no slot in the table; its select is not carried
            func_req[`PPC_F_T0] = peripheral_select_reg_b[`PPC_B_T0];
        end
    end

    // Placement
    ppc_decoder u_dec (
        .func_req    (func_req),
        .bypass      (pin_bypass_mask[`PPC_NPIN-1:0]),
        .big_variant (big_variant),
        .func_pin    (func_pin),
        .func_placed (func_placed),
        .pin_func    (pin_func)
    );

    // ==========================================================
    // Next pad state per pin
    always_comb begin
        logic [`PPC_FIDX_W-1:0] fn;
        logic drv_val;
        logic drv_en;
        logic od;
        logic digital;
        fn = `PPC_NONE;
        drv_val = 1'b0;
        drv_en = 1'b0;
        od = 1'b0;
        digital = 1'b0;
        next_state = state;
        for (int p = 0; p < `PPC_NPIN_ALL; p++) begin
            fn = `PPC_NONE;
            if (p < `PPC_NPIN) begin
                fn = pin_func[p*`PPC_FIDX_W +: `PPC_FIDX_W];
            end
            digital = pin_input_kind_mask[p];
            od = !pin_drive_kind_mask[p]
                || fn == `PPC_F_SDA || fn == `PPC_F_SCL;
            if (fn != `PPC_NONE) begin
                drv_val = periph_out[fn];
                drv_en = periph_oe[fn];
            end else begin
                drv_val = port_latch[p];
                drv_en = 1'b1;
            end
            // Open-drain drives only low
            if (od) begin
                drv_en = drv_en && !drv_val;
            end
            drv_en = drv_en && matrix_enable_bit && digital;
            next_state.pin_out[p] = drv_val && drv_en;
            next_state.pin_oe[p] = drv_en;
            next_state.pin_pullup[p] = od && !pullup_disable_bit
                && digital && !(drv_en && !drv_val);
            next_state.port_read[p] = pin_sync[p] && digital;
        end
    end

    // Peripheral inputs from their placed pins
    always_comb begin
        logic [`PPC_PIDX_W-1:0] pp;
        pp = '0;
        next_periph_in = '0;
        for (int f = 0; f < `PPC_NFUNC; f++) begin
            pp = func_pin[f*`PPC_PIDX_W +: `PPC_PIDX_W];
            if (func_placed[f]) begin
                next_periph_in[f] = pin_sync[pp[4:0]]
                    && pin_input_kind_mask[pp[4:0]];
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
            pin_meta <= '0;
            pin_sync <= '0;
            periph_in_q <= '0;
            placed_q <= '0;
        end else begin
            state <= next_state;
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            periph_in_q <= next_periph_in;
            placed_q <= func_placed;
        end
    end

    // Outputs straight from flops
    assign pin_out = state.pin_out;
    assign pin_oe = state.pin_oe;
    assign pin_pullup = state.pin_pullup;
    assign port_read = state.port_read;
    assign periph_in = periph_in_q;
    assign periph_placed = placed_q;
endmodule // ppc_crossbar
`default_nettype wire

// ### tb/ppc_checker_assertions.sv
// Concurrent checks on the pad and placement outputs of the crossbar
`default_nettype none
`include "ppc_map.svh"
module ppc_checker (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Configuration
    input wire logic [7:0]               peripheral_select_reg_a,
    input wire logic                     big_variant,
    input wire logic                     matrix_enable_bit,
    input wire logic                     pullup_disable_bit,
    input wire ppc_pkg::ppc_pins_t       pin_input_kind_mask,
    input wire ppc_pkg::ppc_pins_t       pin_drive_kind_mask,
    input wire logic [`PPC_NFUNC-1:0]    periph_out,
    input wire logic [`PPC_NFUNC-1:0]    periph_oe,
    input wire ppc_pkg::ppc_pins_t       pin_in,
    // Design outputs
    input wire logic [`PPC_NPIN_ALL-1:0] pin_out,
    input wire logic [`PPC_NPIN_ALL-1:0] pin_oe,
    input wire logic [`PPC_NPIN_ALL-1:0] pin_pullup,
    input wire logic [`PPC_NPIN_ALL-1:0] port_read,
    input wire logic [`PPC_NFUNC-1:0]    periph_placed
);
    import ppc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [2:0] up;
    // Cycles since reset, saturating at four
    always_ff @(posedge clk) up <= rst ? 3'h0 : up + {2'h0, up != 3'h4};

    a_off_no_drive: assert property (
        !$past(matrix_enable_bit) |-> pin_oe == '0) else $error("drive off");
    a_off_no_place: assert property (
        !$past(matrix_enable_bit) |-> periph_placed == '0)
        else $error("placed off");
    a_analog_quiet: assert property (
        ((pin_oe | pin_pullup) & ~$past(pin_input_kind_mask)) == '0)
        else $error("analog pin active");
    a_low_no_pull: assert property (
        (pin_pullup & pin_oe & ~pin_out) == '0) else $error("pull on low");
    a_pull_off: assert property (
        $past(pullup_disable_bit) |-> pin_pullup == '0)
        else $error("pullup left on");
    a_tx_fixed: assert property (
        up != 3'h0 && $past(matrix_enable_bit & peripheral_select_reg_a[0]
        & big_variant & periph_oe[0] & pin_drive_kind_mask[1]
        & pin_input_kind_mask[1])
        |-> pin_oe[1] && pin_out[1] == $past(periph_out[0]))
        else $error("tx pin wrong");
    a_pair_place: assert property (
        up != 3'h0 && $past(matrix_enable_bit & peripheral_select_reg_a[0])
        |-> periph_placed[1:0] == 2'h3) else $error("async pair split");
    a_read_analog: assert property (
        (port_read & ~($past(pin_input_kind_mask) | $past(pin_input_kind_mask,
        2) | $past(pin_input_kind_mask, 3))) == '0)
        else $error("analog read nonzero");
    a_read_level: assert property (
        up == 3'h4 |-> ((port_read ^ $past(pin_in, 3)) & $past(
        pin_input_kind_mask) & $past(pin_input_kind_mask, 3)) == '0)
        else $error("read level wrong");
endmodule // ppc_checker
`default_nettype wire

// ### tb/ppc_board.sv
// Board pads: resolve drivers, pullups and floating pins
`default_nettype none
module ppc_board (
    // Clock
    input wire logic         clk,
    // Pad controls
    input wire logic [38:0]  pin_out,
    input wire logic [38:0]  pin_oe,
    input wire logic [38:0]  pin_pullup,
    // Pad levels
    output logic [38:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [38:0] flt = '0;
    // Floating pins wander every cycle, never hold a value
    always_ff @(posedge clk) flt <= ~flt;
    // Driven, else pulled high, else floating
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | flt));
endmodule // ppc_board
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench of the priority pin crossbar
`default_nettype none
`include "ppc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic        clk, rst, en, pud, big;
    logic [7:0]  sel_a, sel_b;
    logic [1:0]  ss;
    ppc_pins_t   byp, kind, drv, latch, pin_in;
    logic [38:0] p_out, p_oe, p_pu, rd;
    logic [20:0] f_out, f_oe, f_in, placed;
    int          err_count, compares;

    ppc_crossbar dut_u (.clk, .rst, .peripheral_select_reg_a(sel_a),
        .peripheral_select_reg_b(sel_b), .slave_select_mode_field(ss),
        .big_variant(big), .matrix_enable_bit(en),
        .pullup_disable_bit(pud), .pin_bypass_mask(byp),
        .pin_input_kind_mask(kind), .pin_drive_kind_mask(drv),
        .port_latch(latch), .periph_out(f_out), .periph_oe(f_oe),
        .pin_in, .pin_out(p_out), .pin_oe(p_oe), .pin_pullup(p_pu),
        .port_read(rd), .periph_in(f_in), .periph_placed(placed));
    ppc_board brd_u (.clk, .pin_out(p_out), .pin_oe(p_oe),
        .pin_pullup(p_pu), .pin_in);

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_p(input logic [38:0] got, input logic [38:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_f(input logic [20:0] got, input logic [20:0] exp);
        chk_p({18'h0, got}, {18'h0, exp});
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Selections made while the matrix is off
    task automatic t_off;
        {sel_a, sel_b} = 16'hff3f;
        step(2);
        chk_p(p_oe, '0);
        chk_f(placed, '0);
        $display("t_off done");
    endtask

    // Async pair fixed, sync serial placed around it
    task automatic t_prio;
        sel_a = 8'h03;
        sel_b = 8'h00;
        en = 1'b1;
        latch[7] = 1'b1;
        step(2);
        chk_f(placed, 21'h1f);
        chk_p(p_out & ~39'h4, 39'h9b);
        ss = 2'h2;
        step(2);
        chk_p(p_out & ~39'h4, 39'hbb);
        {ss, big} = 3'h0;
        step(2);
        chk_p(p_out & ~39'h20, 39'h97);
        $display("t_prio done");
    endtask

    // Bypassed pins count as occupied
    task automatic t_byp;
        {big, byp} = {1'b1, 39'h9};
        step(2);
        chk_p(p_out & ~39'h4, 39'hf2);
        byp = 39'h00_ffff_ffff;
        sel_a = 8'h02;
        step(2);
        chk_f(placed, '0);
        chk_p(p_out, 39'h80);
        $display("t_byp done");
    endtask

    // Two-wire pins never drive high
    task automatic t_smb;
        {byp, sel_a} = {39'h0, 8'h04};
        step(2);
        chk_f(placed, 21'hc0);
        chk_p(p_oe & 39'h3, '0);
        step(3);
        chk_f(f_in & 21'hc0, 21'hc0);
        f_out = '0;
        step(2);
        chk_p(p_oe & 39'h3, 39'h3);
        step(3);
        chk_f(f_in & 21'hc0, '0);
        $display("t_smb done");
    endtask

    // Every capture count code
    task automatic t_cex;
        sel_a = '0;
        for (int k = 0; k < 8; k++) begin
            sel_b = 8'(k);
            step(2);
            chk_f(placed, 21'((k < 7 ? (1 << k) - 1 : 0) << 13));
        end
        $display("t_cex done");
    endtask

    // Pullups, analog pin and read-back
    task automatic t_pull;
        {sel_b, drv, latch} = {8'h0, 39'h0, ~39'h8};
        kind = ~39'h1;
        byp = 39'h1;
        step(6);
        chk_p(p_pu, ~39'h9);
        chk_p(p_oe, 39'h8);
        chk_p(rd, ~39'h9);
        pud = 1'b1;
        step(2);
        chk_p(p_pu, '0);
        $display("t_pull done");
    endtask

    // Hang guard
    initial begin
        #200000;
        err_count++;
        results();
    end

    // Main sequence
    initial begin
        {rst, en, pud, big, ss} = 6'b10_0100;
        {sel_a, sel_b, byp, latch, f_out} = '0;
        {kind, drv, f_oe} = '1;
        {err_count, compares} = '0;
        step(6);
        rst = 1'b0;
        t_off();
        f_out = '1;
        t_prio();
        t_byp();
        t_smb();
        t_cex();
        t_pull();
        results();
    end
endmodule // tb

bind ppc_crossbar ppc_checker chk_u (.clk, .rst, .peripheral_select_reg_a,
    .big_variant, .matrix_enable_bit, .pullup_disable_bit,
    .pin_input_kind_mask, .pin_drive_kind_mask, .periph_out, .periph_oe,
    .pin_in, .pin_out, .pin_oe, .pin_pullup, .port_read, .periph_placed);
`default_nettype wire
